// ---- testbus_prbs_and_spare_pin_io.sv ----
// Test bus observation, pattern start control and spare parallel pin I/O
`timescale 1ns/10ps
module testbus_prbs_and_spare_pin_io
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [5:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic [1:0] HOST_MODE,
    input wire logic [255:0] TEST_GROUPS,
    input wire logic SEND_CMD,
    input wire logic SECURE_CLOCK_ON_PIN1,
    input wire logic SECURE_CLOCK,
    input wire logic [6:0] PIN_IN,
    output logic [6:0] PIN_OUT,
    output logic [6:0] PIN_OE,
    output logic SERIAL_AUX_LINE_ENABLE,
    output logic PATTERN_BIT,
    output logic PATTERN_ACTIVE,
    output testbus_pkg::pattern_mode_e PATTERN_MODE
);
    import testbus_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] test_select_two;
        logic [7:0] pin_driver_enable;
        logic [7:0] port_pin_value;
        logic [7:0] rdata;
        logic [6:0] pin_out;
        logic [6:0] pin_oe;
    } regs_s;

    regs_s r_q;
    regs_s r_d;

    prbs_link_if link ();

    // Byte of the chosen internal group
    function automatic logic [7:0] pick_group(input logic [255:0] g, input logic [4:0] sel);
        logic [7:0] v;
        v = g[sel * GROUP_WIDTH +: GROUP_WIDTH];
        return v;
    endfunction

    // Test bus bits placed on D4, D3, D2, D6, D5, D0, D1
    function automatic logic [6:0] swap_order(input logic [7:0] b);
        logic [6:0] p;
        p = 7'h00;
        p[4] = b[0];
        p[3] = b[1];
        p[2] = b[2];
        p[6] = b[3];
        p[5] = b[4];
        p[0] = b[5];
        p[1] = b[6];
        return p;
    endfunction

    logic [7:0] observed;
    logic serial_host;
    logic [6:0] usable_mask;
    pattern_mode_e want_mode;

    always_comb
    begin
        observed = pick_group(TEST_GROUPS, r_q.test_select_two[OBSERVE_SELECT_MSB:0]);
        serial_host = (HOST_MODE != HOST_PARALLEL);
        usable_mask = FULL_PIN_MASK;
        if (HOST_MODE == HOST_SPI)
        begin
            usable_mask = NARROW_PIN_MASK;
        end
        else if (HOST_MODE == HOST_UART && r_q.pin_driver_enable[SERIAL_AUX_LINE_ENABLE_BIT])
        begin
            usable_mask = NARROW_PIN_MASK;
        end
        if (SECURE_CLOCK_ON_PIN1)
        begin
            usable_mask[SECURE_CLOCK_PIN] = 1'b0;
        end
        // Host is trusted to have set up transmit first
        if (r_q.test_select_two[PRBS9_ENABLE_BIT])
        begin
            want_mode = PATTERN_NINE;
        end
        else if (r_q.test_select_two[PRBS15_ENABLE_BIT])
        begin
            want_mode = PATTERN_FIFTEEN;
        end
        else
        begin
            want_mode = PATTERN_OFF;
        end
    end

    assign link.mode = want_mode;
    assign link.send = SEND_CMD;

    prbs_gen u_prbs_gen
    (
        .CLK(CLK),
        .RST(RST),
        .link(link)
    );

    // ----------------------------------------
    // Register access and pin drive
    // ----------------------------------------
    always_comb
    begin
        r_d = r_q;
        if (REG_WR)
        begin
            case (REG_ADDR)
                TEST_SELECT_TWO_ADDR:
                    r_d.test_select_two = REG_WDATA;
                PIN_DRIVER_ENABLE_ADDR:
                    r_d.pin_driver_enable = REG_WDATA;
                PORT_PIN_VALUE_ADDR:
                    r_d.port_pin_value = REG_WDATA;
                default:
                    r_d.rdata = r_q.rdata;
            endcase
        end

        // Read data held until the next read
        if (REG_RD)
        begin
            case (REG_ADDR)
                TEST_SELECT_TWO_ADDR:
                    r_d.rdata = r_q.test_select_two;
                PIN_DRIVER_ENABLE_ADDR:
                    r_d.rdata = r_q.pin_driver_enable;
                PORT_PIN_VALUE_ADDR:
                begin
                    if (r_q.port_pin_value[SPARE_PORT_IO_SELECT_BIT])
                    begin
                        r_d.rdata = {r_q.port_pin_value[SPARE_PORT_IO_SELECT_BIT], PIN_IN};
                    end
                    else
                    begin
                        r_d.rdata = r_q.port_pin_value;
                    end
                end
                TEST_BUS_STATUS_ADDR:
                    r_d.rdata = observed;
                default:
                    r_d.rdata = READ_IDLE_VALUE;
            endcase
        end

        // Parallel host owns the port, nothing driven here
        r_d.pin_out = 7'h00;
        r_d.pin_oe = 7'h00;
        if (serial_host)
        begin
            if (r_q.test_select_two[BUS_ORDER_SWAP_BIT])
            begin
                r_d.pin_out = swap_order(observed);
                r_d.pin_oe = FULL_PIN_MASK;
            end
            else if (r_q.port_pin_value[SPARE_PORT_IO_SELECT_BIT])
            begin
                // Each enable gates its own pin, level from the value field
                r_d.pin_out = r_q.port_pin_value[PIN_FIELD_MSB:0] & usable_mask;
                r_d.pin_oe = r_q.pin_driver_enable[PIN_FIELD_MSB:0] & usable_mask;
            end
            if (SECURE_CLOCK_ON_PIN1)
            begin
                // Clock lags one cycle through this flop
                r_d.pin_out[SECURE_CLOCK_PIN] = SECURE_CLOCK;
                r_d.pin_oe[SECURE_CLOCK_PIN] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            r_q.test_select_two <= TEST_SELECT_TWO_RESET;
            r_q.pin_driver_enable <= PIN_DRIVER_ENABLE_RESET;
            r_q.port_pin_value <= PORT_PIN_VALUE_RESET;
            r_q.rdata <= READ_IDLE_VALUE;
            r_q.pin_out <= 7'h00;
            r_q.pin_oe <= 7'h00;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign REG_RDATA = r_q.rdata;
    assign PIN_OUT = r_q.pin_out;
    assign PIN_OE = r_q.pin_oe;
    assign SERIAL_AUX_LINE_ENABLE = r_q.pin_driver_enable[SERIAL_AUX_LINE_ENABLE_BIT];
    assign PATTERN_BIT = link.bit_out;
    assign PATTERN_ACTIVE = link.running;
    assign PATTERN_MODE = want_mode;
endmodule

// ---- testbus_pkg.sv ----
// Shared constants and types for the test bus, pattern generator and spare pin logic
package testbus_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [5:0] TEST_SELECT_TWO_ADDR = 6'h32;
    localparam logic [5:0] PIN_DRIVER_ENABLE_ADDR = 6'h33;
    localparam logic [5:0] PORT_PIN_VALUE_ADDR = 6'h34;
    localparam logic [5:0] TEST_BUS_STATUS_ADDR = 6'h35;

    localparam logic [7:0] TEST_SELECT_TWO_RESET = 8'h00;
    localparam logic [7:0] PIN_DRIVER_ENABLE_RESET = 8'h80;
    localparam logic [7:0] PORT_PIN_VALUE_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE_VALUE = 8'h00;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BUS_ORDER_SWAP_BIT = 7;
    localparam int PRBS9_ENABLE_BIT = 6;
    localparam int PRBS15_ENABLE_BIT = 5;
    localparam int OBSERVE_SELECT_MSB = 4;
    localparam int SERIAL_AUX_LINE_ENABLE_BIT = 7;
    localparam int SPARE_PORT_IO_SELECT_BIT = 7;
    localparam int PIN_FIELD_MSB = 6;

    localparam int PIN_COUNT = 7;
    localparam int GROUP_COUNT = 32;
    localparam int GROUP_WIDTH = 8;
    localparam int SECURE_CLOCK_PIN = 1;

    // Pins usable as spare I/O when the serial line is shared
    localparam logic [6:0] NARROW_PIN_MASK = 7'h1F;
    localparam logic [6:0] FULL_PIN_MASK = 7'h7F;

    // ----------------------------------------
    // Host interface modes
    // ----------------------------------------
    localparam logic [1:0] HOST_PARALLEL = 2'h0;
    localparam logic [1:0] HOST_SPI = 2'h1;
    localparam logic [1:0] HOST_UART = 2'h2;
    localparam logic [1:0] HOST_I2C = 2'h3;

    // ----------------------------------------
    // Pattern generator
    // ----------------------------------------
    localparam logic [14:0] PRBS_SEED = 15'h7FFF;

    typedef enum logic [1:0] {
        PATTERN_OFF,
        PATTERN_NINE,
        PATTERN_FIFTEEN
    } pattern_mode_e;

endpackage

// ---- prbs_link_if.sv ----
// Link between the register block and the pattern generator
`timescale 1ns/10ps
interface prbs_link_if;
    import testbus_pkg::*;

    pattern_mode_e mode;
    logic send;
    logic bit_out;
    logic running;

    modport ctrl
    (
        output mode,
        output send,
        input bit_out,
        input running
    );

    modport gen
    (
        input mode,
        input send,
        output bit_out,
        output running
    );
endinterface

// ---- prbs_gen.sv ----
// Pseudo-random transmit pattern generator, nine or fifteen stages
`timescale 1ns/10ps
module prbs_gen
(
    input wire logic CLK,
    input wire logic RST,
    prbs_link_if.gen link
);
    import testbus_pkg::*;

    typedef enum logic [0:0] {
        GEN_IDLE,
        GEN_RUN
    } gen_state_e;

    typedef struct packed {
        gen_state_e state;
        pattern_mode_e run_mode;
        logic [14:0] shift;
        logic bit_out;
    } gen_s;

    gen_s s_q;
    gen_s s_d;

    // Feedback tap of the selected polynomial
    function automatic logic feedback(input pattern_mode_e m, input logic [14:0] r);
        logic fb;
        fb = 1'b0;
        case (m)
            PATTERN_NINE:
                fb = r[8] ^ r[4];
            PATTERN_FIFTEEN:
                fb = r[14] ^ r[13];
            default:
                fb = 1'b0;
        endcase
        return fb;
    endfunction

    always_comb
    begin
        s_d = s_q;
        case (s_q.state)
            GEN_IDLE:
            begin
                s_d.bit_out = 1'b0;
                s_d.shift = PRBS_SEED;
                // Nothing leaves the generator before the send command
                if (link.send && link.mode != PATTERN_OFF)
                begin
                    s_d.state = GEN_RUN;
                    s_d.run_mode = link.mode;
                end
            end
            GEN_RUN:
            begin
                // x^9+x^5+1 or x^15+x^14+1, oldest stage shifted out
                s_d.bit_out = (s_q.run_mode == PATTERN_NINE) ? s_q.shift[8] : s_q.shift[14];
                s_d.shift = {s_q.shift[13:0], feedback(s_q.run_mode, s_q.shift)};
                // Mode change mid-sequence restarts cleanly on the next send
                if (link.mode != s_q.run_mode)
                begin
                    s_d.state = GEN_IDLE;
                end
            end
            default:
                s_d.state = GEN_IDLE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            s_q <= '{state: GEN_IDLE, run_mode: PATTERN_OFF, shift: PRBS_SEED, bit_out: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign link.bit_out = s_q.bit_out;
    assign link.running = (s_q.state == GEN_RUN);
endmodule

// ---- testbus_props.sv ----
// Port-level assertions for the test bus, pattern and spare pin block
`timescale 1ns/10ps
module testbus_props
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [5:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic [1:0] HOST_MODE,
    input wire logic [255:0] TEST_GROUPS,
    input wire logic SEND_CMD,
    input wire logic SECURE_CLOCK_ON_PIN1,
    input wire logic SECURE_CLOCK,
    input wire logic [6:0] PIN_IN,
    input wire logic [6:0] PIN_OUT,
    input wire logic [6:0] PIN_OE,
    input wire logic SERIAL_AUX_LINE_ENABLE,
    input wire logic PATTERN_ACTIVE,
    input wire testbus_pkg::pattern_mode_e PATTERN_MODE
);
    import testbus_pkg::*;
    // ------
    // Shadow of the writable registers
    // ------
    logic [7:0] sel_q, en_q, val_q, grp, rb;
    logic [6:0] msk, sw, oe_x, out_x;
    logic io;
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            sel_q <= 8'h00;
            en_q <= 8'h80;
            val_q <= 8'h00;
        end
        else if (REG_WR)
        begin
            if (REG_ADDR == 6'h32)
                sel_q <= REG_WDATA;
            if (REG_ADDR == 6'h33)
                en_q <= REG_WDATA;
            if (REG_ADDR == 6'h34)
                val_q <= REG_WDATA;
        end
    end
    assign grp = TEST_GROUPS[8 * sel_q[4:0] +: 8];
    assign sw = {grp[3], grp[4], grp[0], grp[1], grp[2], grp[6], grp[5]};
    assign rb = val_q[7] ? {1'b1, PIN_IN} : val_q;
    assign msk = (HOST_MODE == HOST_SPI || (HOST_MODE == HOST_UART && en_q[7])) ? 7'h1F : 7'h7F;
    assign oe_x = en_q[6:0] & msk;
    assign out_x = val_q[6:0] & msk;
    assign io = val_q[7] && !sel_q[7] && HOST_MODE != HOST_PARALLEL && !SECURE_CLOCK_ON_PIN1;
    // ------
    // Properties
    // ------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    a_parallel_quiet: assert property (HOST_MODE == HOST_PARALLEL |=> PIN_OE == 7'h00)
        else $error("pin driven in parallel mode");
    a_nine_wins: assert property (REG_WR && REG_ADDR == 6'h32 && REG_WDATA[6]
        |=> PATTERN_MODE == PATTERN_NINE) else $error("nine-stage mode not set");
    a_send_starts: assert property (SEND_CMD && PATTERN_MODE != PATTERN_OFF
        && !PATTERN_ACTIVE |=> PATTERN_ACTIVE) else $error("send did not start");
    a_aux_follow: assert property (REG_WR && REG_ADDR == 6'h33
        |=> SERIAL_AUX_LINE_ENABLE == $past(REG_WDATA[7])) else $error("aux enable wrong");
    a_status_read: assert property (REG_RD && REG_ADDR == 6'h35
        |=> REG_RDATA == $past(grp)) else $error("status read wrong");
    a_level_read: assert property (REG_RD && REG_ADDR == 6'h34
        |=> REG_RDATA == $past(rb)) else $error("level read wrong");
    a_spare_drive: assert property (io |=> PIN_OE == $past(oe_x)
        && PIN_OUT == $past(out_x)) else $error("spare pins wrong");
    a_swap_order: assert property (sel_q[7] && HOST_MODE != HOST_PARALLEL
        && !SECURE_CLOCK_ON_PIN1 |=> PIN_OUT == $past(sw)) else $error("swap order wrong");
    a_secure_pin: assert property (SECURE_CLOCK_ON_PIN1 && val_q[7] && !sel_q[7]
        && HOST_MODE != HOST_PARALLEL |=> PIN_OUT[1] == $past(SECURE_CLOCK))
        else $error("secure clock not on pin 1");
    c_fifteen: cover property (PATTERN_ACTIVE && PATTERN_MODE == PATTERN_FIFTEEN);
    c_spare: cover property (io);
    c_swap: cover property (sel_q[7] && HOST_MODE != HOST_PARALLEL);
endmodule

// ---- host_model.sv ----
// Host microcontroller model issuing single-byte register accesses
`timescale 1ns/10ps
module host_model
(
    input wire logic clk,
    output logic [5:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata
);
    initial
    begin
        addr = 6'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // Idle lines show inverted junk so stale values never pass
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
        @(posedge clk);
        #1;
    endtask
    task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
        addr = a;
        rd = 1'b1;
        @(posedge clk);
        #1;
        rd = 1'b0;
        addr = ~a;
        d = rdata;
        @(posedge clk);
        #1;
    endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench for the test bus, pattern and spare pin block
`timescale 1ns/10ps
module testbench;
    import testbus_pkg::*;
    logic clk = 0, rst = 1, send = 0, sck_on = 0, sck = 0, pbit, pact, aux, rd, wr, b;
    logic [1:0] mode = 2'h0;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, g;
    logic [6:0] ext = 7'h56, pin_in, pin_out, pin_oe;
    logic [255:0] groups;
    logic [14:0] s;
    logic [1:0] tm [5] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
    logic [7:0] te [5] = '{8'h7F, 8'hFF, 8'h7F, 8'h7F, 8'h7F};
    logic [6:0] to [5] = '{7'h1F, 7'h1F, 7'h7F, 7'h7F, 7'h00};
    pattern_mode_e pmode;
    int errors = 0, compares = 0;
    // Wire level: our drive where enabled, far side elsewhere
    assign pin_in = rst ? ext : (pin_oe & pin_out) | (~pin_oe & ext);
    host_model i_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    testbus_prbs_and_spare_pin_io i_dut
    (
        .CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdata), .HOST_MODE(mode), .TEST_GROUPS(groups), .SEND_CMD(send),
        .SECURE_CLOCK_ON_PIN1(sck_on), .SECURE_CLOCK(sck), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .SERIAL_AUX_LINE_ENABLE(aux), .PATTERN_BIT(pbit),
        .PATTERN_ACTIVE(pact), .PATTERN_MODE(pmode)
    );
    initial
    begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) sck <= #1 ~sck;
    initial
    begin
        #400000;
        errors++;
        conclude();
    end
    // ------
    // Helpers
    // ------
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task rchk(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd_reg(a, d);
        chk(d, e);
    endtask
    task tick();
        @(posedge clk);
        #1;
    endtask
    task done(input string t);
        $display("test %s done", t);
    endtask
    task conclude();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ------
    // Main sequence
    // ------
    initial
    begin
        for (int n = 0; n < 32; n++)
            groups[8 * n +: 8] = 8'(n * 29 + 75);
        repeat (2) @(posedge clk);
        #1;
        rst = 0;
        rchk(6'h32, 8'h00);
        rchk(6'h33, 8'h80);
        // Unmapped read right after a nonzero one, so stale data cannot pass
        rchk(6'h3F, 8'h00);
        rchk(6'h34, 8'h00);
        chk({7'h00, aux}, 8'h01);
        done("reset");
        for (int k = 5; k < 32; k += 13)
        begin
            i_host.wr_reg(6'h32, 8'(k));
            rchk(6'h35, groups[8 * k +: 8]);
        end
        i_host.wr_reg(6'h35, 8'h00);
        rchk(6'h35, groups[8 * 31 +: 8]);
        i_host.wr_reg(6'h33, 8'h00);
        chk({7'h00, aux}, 8'h00);
        done("status");
        i_host.wr_reg(6'h32, 8'h00);
        i_host.wr_reg(6'h34, 8'hFF);
        for (int k = 0; k < 5; k++)
        begin
            mode = tm[k];
            i_host.wr_reg(6'h33, te[k]);
            tick();
            chk({1'b0, pin_oe}, {1'b0, to[k]});
        end
        mode = 2'h1;
        i_host.wr_reg(6'h33, 8'h03);
        i_host.wr_reg(6'h34, 8'h81);
        tick();
        chk({pin_oe, pin_out[0]}, 8'h07);
        rchk(6'h34, 8'hD5);
        sck_on = 1;
        for (int k = 0; k < 3; k++)
        begin
            // Sample the clock level between edges, where it is settled
            @(negedge clk);
            b = sck;
            tick();
            chk({6'h00, pin_oe[1], pin_out[1]}, {6'h00, 1'b1, b});
        end
        sck_on = 0;
        i_host.wr_reg(6'h34, 8'h2A);
        rchk(6'h34, 8'h2A);
        done("spare pins");
        i_host.wr_reg(6'h32, 8'h89);
        tick();
        g = groups[8 * 9 +: 8];
        chk({1'b0, pin_out}, {1'b0, g[3], g[4], g[0], g[1], g[2], g[6], g[5]});
        chk({1'b0, pin_oe}, 8'h7F);
        i_host.wr_reg(6'h32, 8'h00);
        done("swap");
        for (int m = 0; m < 2; m++)
        begin
            send = 1;
            tick();
            send = 0;
            tick();
            chk({7'h00, pact}, 8'h00);
            // Transmit setup is finished before enabling
            i_host.wr_reg(6'h32, m ? 8'h20 : 8'h60);
            repeat (3) tick();
            chk({7'h00, pact}, 8'h00);
            chk({6'h00, pmode}, {6'h00, m ? PATTERN_FIFTEEN : PATTERN_NINE});
            send = 1;
            tick();
            send = 0;
            for (int n = 0; n < 4 && pact !== 1'b1; n++)
                tick();
            if (pact !== 1'b1)
            begin
                $display("[ERR] %0t pattern did not start", $time);
                errors++;
                conclude();
            end
            s = 15'h7FFF;
            for (int k = 0; k < 40; k++)
            begin
                tick();
                b = m ? s[14] : s[8];
                chk({7'h00, pbit}, {7'h00, b});
                s = {s[13:0], m ? s[14] ^ s[13] : s[8] ^ s[4]};
            end
            i_host.wr_reg(6'h32, 8'h00);
            chk({7'h00, pact}, 8'h00);
        end
        done("pattern");
        conclude();
    end
endmodule
bind testbus_prbs_and_spare_pin_io testbus_props i_props
(
    .CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .HOST_MODE(HOST_MODE), .TEST_GROUPS(TEST_GROUPS),
    .SEND_CMD(SEND_CMD), .SECURE_CLOCK_ON_PIN1(SECURE_CLOCK_ON_PIN1),
    .SECURE_CLOCK(SECURE_CLOCK), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .SERIAL_AUX_LINE_ENABLE(SERIAL_AUX_LINE_ENABLE), .PATTERN_ACTIVE(PATTERN_ACTIVE),
    .PATTERN_MODE(PATTERN_MODE)
);
